// *** bench/sfe_front_end_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfe_front_end_tb
    import sfe_pkg::*;
;
    localparam int CEIL = 30000;
    logic core_clk, arst_n, cs_n, sck, si, so, so_oe;
    logic [17:0] mem_addr;
    logic [7:0] mem_wr_data, status_reg;
    logic [7:0] mem_rd_data = 8'h00;
    logic mem_wr_stb, mem_rd_stb, sleep_stb, write_latch_flag;
    logic [25:0] wr_q[$];
    int n_fail = 0;
    int total_checks = 0;
    int n_slp = 0;
    int tick = 0;

    sfe_front_end #(.ADDR_W(18)) dut_u (
        .core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so), .so_oe(so_oe), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data),
        .mem_wr_stb(mem_wr_stb), .mem_rd_stb(mem_rd_stb), .mem_rd_data(mem_rd_data),
        .sleep_stb(sleep_stb), .write_latch_flag(write_latch_flag),
        .status_reg(status_reg)
    );

    sfe_spi_master mst_u (
        .core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe)
    );

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // memory side: log writes, answer reads, count sleeps, watch for hangs
    always @(posedge core_clk) begin
        if (mem_wr_stb === 1'b1) begin
            wr_q.push_back({mem_addr, mem_wr_data});
        end
        if (mem_rd_stb === 1'b1) begin
            mem_rd_data <= mem_addr[7:0] ^ 8'h5A;
        end
        if (sleep_stb === 1'b1) begin
            n_slp++;
        end
        tick++;
        if (tick == CEIL) begin
            n_fail++;
            $display("timeout after %0d cycles", tick);
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one selection of n whole bytes, returns the last two bytes read
    task automatic frame(input logic m3, input int n, input logic [47:0] b,
                         output logic [15:0] rx2);
        logic [7:0] rx;
        rx2 = 16'h0000;
        mst_u.sel(m3);
        for (int k = 0; k < n; k++) begin
            mst_u.xfer(b[47 - 8 * k -: 8], 8, rx);
            rx2 = {rx2[7:0], rx};
        end
        mst_u.desel();
    endtask

    task automatic t_reset();
        chk("latch at reset", 0, write_latch_flag);
        chk("status at reset", 8'h40, status_reg);
        chk("oe at reset", 0, so_oe);
        $display("test reset done");
    endtask

    task automatic t_status();
        logic [15:0] r;
        frame(1'b0, 2, {OP_SR_READ, 40'h0}, r);
        chk("status read mode 0", 8'h40, r[7:0]);
        chk("status read oe bits", 8, mst_u.oe_hits);
        frame(1'b1, 1, {OP_SET_LATCH, 40'h0}, r);
        chk("latch set mode 3", 1, write_latch_flag);
        frame(1'b1, 2, {OP_SR_READ, 40'h0}, r);
        chk("status read mode 3", 8'h42, r[7:0]);
        $display("test status read done");
    endtask

    task automatic t_latch();
        logic [7:0] rx;
        mst_u.sel(1'b0);
        mst_u.xfer(OP_CLR_LATCH, 7, rx);
        mst_u.desel();
        chk("latch after short opcode", 1, write_latch_flag);
        mst_u.sel(1'b0);
        mst_u.xfer(OP_CLR_LATCH, 8, rx);
        mst_u.wait_c(8);
        chk("latch before deselect", 1, write_latch_flag);
        mst_u.desel();
        chk("latch after clear", 0, write_latch_flag);
        mst_u.xfer(OP_SET_LATCH, 8, rx);
        mst_u.wait_c(8);
        chk("latch while deselected", 0, write_latch_flag);
        chk("oe while deselected", 0, so_oe);
        $display("test latch done");
    endtask

    task automatic t_write();
        logic [15:0] r;
        wr_q.delete();
        frame(1'b0, 5, {OP_MEM_WRITE, 24'h000010, 8'h5A, 8'h00}, r);
        chk("write without latch", 0, wr_q.size());
        frame(1'b1, 1, {OP_SET_LATCH, 40'h0}, r);
        frame(1'b1, 6, {OP_MEM_WRITE, 24'hFFFFFE, 8'hA5, 8'h3C}, r);
        chk("write count", 2, wr_q.size());
        chk("first write", {18'h3FFFE, 8'hA5}, wr_q[0]);
        chk("second write", {18'h3FFFF, 8'h3C}, wr_q[1]);
        chk("latch after write", 0, write_latch_flag);
        $display("test memory write done");
    endtask

    task automatic t_sr_write();
        logic [15:0] r;
        frame(1'b0, 1, {OP_SET_LATCH, 40'h0}, r);
        frame(1'b0, 2, {OP_SR_WRITE, 8'hFF, 32'h0}, r);
        chk("status written", 8'hCC, status_reg);
        chk("latch after status write", 0, write_latch_flag);
        frame(1'b0, 2, {OP_SR_WRITE, 8'h00, 32'h0}, r);
        chk("status write refused", 8'hCC, status_reg);
        frame(1'b1, 1, {OP_SET_LATCH, 40'h0}, r);
        frame(1'b1, 2, {OP_SR_WRITE, 8'h00, 32'h0}, r);
        chk("status restored", 8'h40, status_reg);
        $display("test status write done");
    endtask

    task automatic t_read();
        logic [15:0] r;
        frame(1'b1, 6, {OP_MEM_READ, 24'h000123, 16'h0}, r);
        chk("read bytes", 16'h797E, r);
        chk("read oe bits", 16, mst_u.oe_hits);
        $display("test memory read done");
    endtask

    task automatic t_invalid();
        logic [15:0] r;
        logic [7:0] bad [4] = '{8'hFF, 8'h00, 8'h07, 8'hB8};
        foreach (bad[i]) begin
            frame(1'b0, 3, {bad[i], OP_SET_LATCH, 8'h00, 24'h0}, r);
            chk("latch after bad opcode", 0, write_latch_flag);
            chk("oe after bad opcode", 0, mst_u.oe_hits);
        end
        frame(1'b1, 2, {OP_SR_READ, OP_SET_LATCH, 32'h0}, r);
        chk("second opcode ignored", 0, write_latch_flag);
        chk("no sleep yet", 0, n_slp);
        frame(1'b0, 1, {OP_SLEEP, 40'h0}, r);
        chk("sleep strobe", 1, n_slp);
        $display("test opcodes done");
    endtask

    task automatic results();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // reset, then the scenarios in order
    initial begin
        arst_n = 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_status();
        t_latch();
        t_write();
        t_sr_write();
        t_read();
        t_invalid();
        results();
    end
endmodule

`default_nettype wire

// *** bench/sfe_spi_master.sv ***
`timescale 1ns/1ps
`default_nettype none

// behavioural serial bus master driving the front end pins
module sfe_spi_master (
    input wire logic core_clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic mode3;
    int oe_hits;

    // idle: deselected, clock low, data low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        mode3 = 1'b0;
        oe_hits = 0;
    end

    task automatic wait_c(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // park the clock at the mode level before selecting
    task automatic sel(input logic m3);
        mode3 = m3;
        oe_hits = 0;
        @(posedge core_clk);
        sck <= m3;
        wait_c(8);
        cs_n <= 1'b0;
        wait_c(4);
    endtask

    // msb first, data changes on fall, read back on rise
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - nb; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            wait_c(4);
            // undriven line reads as the inverse of the last bit
            rx = {rx[6:0], (so_oe === 1'b1) ? so : ~rx[0]};
            if (so_oe === 1'b1) begin
                oe_hits++;
            end
            sck <= 1'b1;
            wait_c(4);
        end
    endtask

    // clock back to idle level, deselect, invert data
    task automatic desel();
        sck <= mode3;
        wait_c(4);
        cs_n <= 1'b1;
        si <= ~si;
        wait_c(8);
    endtask
endmodule

`default_nettype wire

// *** hw/sfe_front_end.sv ***
// How it works
// - input sampled on clock rise, output changes on clock fall, both modes
// - clock level at select fall picks mode 0 (low) or 3 (high)
// - mode 3 counts bits only after the clock has gone low once
// - first eight bits after select are the opcode, then address and data
// - one opcode per selection, next needs a new select fall
// - while deselected, input ignored and output tristated
// - every byte shifts most significant bit first
// - three address bytes, only the low address bits kept
// - unknown opcode: nothing done, rest ignored, output tristated
// - 06h sets the write latch, 04h clears it
// - 05h reads status, 01h writes status
// - write latch is clear after reset
// - status and memory writes refused while write latch is clear
// - status write never writes the latch flag bit itself
// - latch cleared at deselect after clear, status write or memory write
// - status shows the latch as one when writes are allowed
// - status register is eight bits, returned by status read
// - write latch flag sits at status bit 1
// - output driven only while returning read data
`timescale 1ns/1ps
`default_nettype none

module sfe_front_end
    import sfe_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_stb,
    output logic mem_rd_stb,
    input wire logic [7:0] mem_rd_data,
    output logic sleep_stb,
    output logic write_latch_flag,
    output logic [7:0] status_reg
);
    // the address is assembled from whole bytes and must fit three of them
    if (ADDR_W < 9 || ADDR_W > 24) begin : g_addr_check
        $error("sfe_front_end: ADDR_W must be 9 to 24");
    end

    typedef struct packed {
        sfe_state_t state;
        logic mode3;
        logic armed;
        logic [2:0] bitcnt;
        logic [1:0] bytecnt;
        logic [7:0] shreg;
        logic [7:0] oshreg;
        logic [7:0] op;
        logic wlatch;
        logic clr_pend;
        logic wpen;
        logic [1:0] bp;
        logic [ADDR_W-1:0] addr;
        logic so;
        logic so_oe;
        logic [7:0] wr_data;
        logic wr_stb;
        logic rd_stb;
        logic sleep_stb;
        logic wr_inc;
    } sfe_fe_t;

    sfe_fe_t st_r;
    sfe_fe_t st_nxt;
    sfe_pin_if p ();

    logic [7:0] in_byte;
    logic byte_done;
    logic [7:0] sr_byte;
    logic [7:0] out_src;
    logic set_hit;

    // shift one bit in at the bottom, so the first bit ends up on top
    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b);
        return {cur[6:0], b};
    endfunction

    sfe_pin_sync u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .pins(p)
    );

    // status byte from stored bits and fixed ones
    always_comb begin
        sr_byte = SR_FIXED;
        sr_byte[SR_LATCH_BIT] = st_r.wlatch;
        sr_byte[SR_BP0_BIT] = st_r.bp[0];
        sr_byte[SR_BP1_BIT] = st_r.bp[1];
        sr_byte[SR_WPEN_BIT] = st_r.wpen;
    end

    assign in_byte = shift_in(st_r.shreg, p.si_lvl);
    assign byte_done = (st_r.bitcnt == BIT_LAST);
    assign out_src = (st_r.op == OP_SR_READ) ? sr_byte : mem_rd_data;
    assign set_hit = p.cs_act && !p.cs_fall && p.sck_rise && st_r.armed
        && st_r.state == S_OPCODE && byte_done && in_byte == OP_SET_LATCH;

    // protocol engine on sampled select, clock and data edges
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_stb = 1'b0;
        st_nxt.rd_stb = 1'b0;
        st_nxt.sleep_stb = 1'b0;
        st_nxt.wr_inc = 1'b0;
        if (st_r.wr_inc) begin
            st_nxt.addr = st_r.addr + 1'b1; // rolls over at the top address
        end
        if (!p.cs_act) begin
            // deselected: everything back to opcode bit seven
            if (p.cs_rise && st_r.clr_pend) begin
                st_nxt.wlatch = 1'b0;
            end
            st_nxt.state = S_IDLE;
            st_nxt.bitcnt = BIT_MSB;
            st_nxt.bytecnt = 2'h0;
            st_nxt.clr_pend = 1'b0;
            st_nxt.armed = 1'b0;
            st_nxt.so_oe = 1'b0;
        end else if (p.cs_fall) begin
            // clock level at select decides the mode
            st_nxt.state = S_OPCODE;
            st_nxt.mode3 = p.sck_lvl;
            st_nxt.armed = !p.sck_lvl;
            st_nxt.bitcnt = BIT_MSB;
        end else begin
            if (p.sck_fall) begin
                st_nxt.armed = 1'b1;
            end
            if (p.sck_rise && st_r.armed) begin
                st_nxt.shreg = in_byte;
                st_nxt.bitcnt = st_r.bitcnt - 3'h1; // wraps to bit seven
                unique case (st_r.state)
                    S_OPCODE: begin
                        if (byte_done) begin
                            // whole opcode in hand before acting
                            st_nxt.op = in_byte;
                            unique case (in_byte)
                                OP_SET_LATCH: begin
                                    st_nxt.wlatch = 1'b1;
                                    st_nxt.state = S_DONE;
                                end
                                OP_CLR_LATCH: begin
                                    st_nxt.clr_pend = 1'b1;
                                    st_nxt.state = S_DONE;
                                end
                                OP_SR_READ: begin
                                    st_nxt.state = S_DATA_OUT;
                                end
                                OP_SR_WRITE: begin
                                    st_nxt.clr_pend = 1'b1;
                                    st_nxt.state = st_r.wlatch ? S_DATA_IN : S_IGNORE;
                                end
                                OP_MEM_READ: begin
                                    st_nxt.state = S_ADDR;
                                end
                                OP_MEM_WRITE: begin
                                    st_nxt.clr_pend = 1'b1;
                                    st_nxt.state = st_r.wlatch ? S_ADDR : S_IGNORE;
                                end
                                OP_SLEEP: begin
                                    st_nxt.sleep_stb = 1'b1;
                                    st_nxt.state = S_DONE;
                                end
                                default: begin
                                    st_nxt.state = S_IGNORE;
                                end
                            endcase
                        end
                    end
                    S_ADDR: begin
                        if (byte_done) begin
                            // leading bits fall off the top
                            st_nxt.addr = {st_r.addr[ADDR_W-9:0], in_byte};
                            st_nxt.bytecnt = st_r.bytecnt + 2'h1;
                            if (st_r.bytecnt == ADDR_BYTE_LAST) begin
                                if (st_r.op == OP_MEM_READ) begin
                                    st_nxt.state = S_DATA_OUT;
                                    st_nxt.rd_stb = 1'b1;
                                end else begin
                                    st_nxt.state = S_DATA_IN;
                                end
                            end
                        end
                    end
                    S_DATA_IN: begin
                        if (byte_done) begin
                            if (st_r.op == OP_SR_WRITE) begin
                                // latch flag and fixed bits are not writable
                                st_nxt.wpen = in_byte[SR_WPEN_BIT];
                                st_nxt.bp = {in_byte[SR_BP1_BIT], in_byte[SR_BP0_BIT]};
                                st_nxt.state = S_DONE;
                            end else begin
                                st_nxt.wr_data = in_byte;
                                st_nxt.wr_stb = 1'b1;
                                st_nxt.wr_inc = 1'b1;
                            end
                        end
                    end
                    S_DATA_OUT: begin
                        if (byte_done && st_r.op == OP_MEM_READ) begin
                            st_nxt.addr = st_r.addr + 1'b1;
                            st_nxt.rd_stb = 1'b1;
                        end
                    end
                    S_IDLE, S_IGNORE, S_DONE: begin
                        st_nxt.state = st_r.state;
                    end
                endcase
            end
            if (p.sck_fall && st_r.state == S_DATA_OUT) begin
                // output moves on falling edges only
                st_nxt.so_oe = 1'b1;
                if (st_r.bitcnt == BIT_MSB) begin
                    st_nxt.so = out_src[7];
                    st_nxt.oshreg = {out_src[6:0], 1'b0};
                end else begin
                    st_nxt.so = st_r.oshreg[7];
                    st_nxt.oshreg = {st_r.oshreg[6:0], 1'b0};
                end
            end
        end
    end

    // latch cleared and decode idle after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
            st_r.state <= S_IDLE;
            st_r.bitcnt <= BIT_MSB;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign so = st_r.so;
    assign so_oe = st_r.so_oe;
    assign mem_addr = st_r.addr;
    assign mem_wr_data = st_r.wr_data;
    assign mem_wr_stb = st_r.wr_stb;
    assign mem_rd_stb = st_r.rd_stb;
    assign sleep_stb = st_r.sleep_stb;
    assign write_latch_flag = st_r.wlatch;
    assign status_reg = {st_r.wpen, SR_FIXED[6:4], st_r.bp, st_r.wlatch, SR_FIXED[0]};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // checks on the protocol engine
    oe_deselect_a: assert property (!p.cs_act |=> !st_r.so_oe)
        else $error("output enabled while deselected");
    oe_only_read_a: assert property (st_r.so_oe |-> $past(st_r.state) == S_DATA_OUT)
        else $error("output enabled outside read data");
    so_on_fall_a: assert property ($changed(st_r.so) |-> $past(p.sck_fall))
        else $error("serial output moved off a falling edge");
    mode_latch_a: assert property (p.cs_fall |=> st_r.mode3 == $past(p.sck_lvl))
        else $error("clock mode not taken at select");
    mode3_wait_a: assert property (st_r.state == S_OPCODE && st_r.mode3 && !st_r.armed
        |-> st_r.bitcnt == BIT_MSB)
        else $error("mode 3 counted a bit before clock went low");
    deselect_reset_a: assert property (!p.cs_act |=> st_r.state == S_IDLE
        && st_r.bitcnt == BIT_MSB)
        else $error("deselect did not reset decode");
    new_op_a: assert property (st_r.state == S_OPCODE && $past(st_r.state) != S_OPCODE
        |-> $past(p.cs_fall))
        else $error("opcode phase entered without select fall");
    ignore_hold_a: assert property (st_r.state == S_IGNORE |=> (st_r.state == S_IGNORE
        || st_r.state == S_IDLE) && !st_r.so_oe && !st_r.wr_stb)
        else $error("invalid opcode caused activity");
    latch_set_a: assert property (set_hit |=> st_r.wlatch)
        else $error("set latch opcode did not set latch");
    latch_rise_a: assert property ($rose(st_r.wlatch) |-> $past(set_hit))
        else $error("latch set by something other than set opcode");
    latch_clear_a: assert property (p.cs_rise && st_r.clr_pend |=> !st_r.wlatch)
        else $error("latch not cleared at deselect");
    write_needs_latch_a: assert property (st_r.wr_stb |-> st_r.wlatch)
        else $error("memory write with latch clear");
    sr_flag_a: assert property (status_reg[SR_LATCH_BIT] == st_r.wlatch
        && status_reg[6] == 1'b1)
        else $error("status byte layout wrong");

    // checks on decode, strobes and data paths
    quiet_deselect_a: assert property (!p.cs_act
        |=> !st_r.wr_stb && !st_r.rd_stb && !st_r.sleep_stb)
        else $error("strobe raised while deselected");
    unarmed_hold_a: assert property (p.cs_act && !p.cs_fall && !st_r.armed
        |=> st_r.bitcnt == $past(st_r.bitcnt))
        else $error("bit counted while waiting for the first clock fall");
    msb_first_a: assert property (p.cs_act && !p.cs_fall && p.sck_rise && st_r.armed
        |=> st_r.shreg == {$past(st_r.shreg[6:0]), $past(p.si_lvl)})
        else $error("input bit not shifted in at the bottom");
    whole_opcode_a: assert property (st_r.state != S_OPCODE
        && $past(st_r.state) == S_OPCODE
        |-> $past(st_r.bitcnt) == BIT_LAST || !$past(p.cs_act))
        else $error("opcode decoded before its eighth bit");
    single_op_a: assert property (st_r.state != S_OPCODE && st_r.state != S_IDLE
        |=> st_r.state != S_OPCODE)
        else $error("second opcode phase without deselect");
    addr_low_a: assert property (st_r.state == S_ADDR && p.cs_act && !p.cs_fall
        && p.sck_rise && st_r.armed && byte_done
        |=> st_r.addr[7:0] == $past(in_byte))
        else $error("address byte not taken into the low bits");
    addr_step_a: assert property (st_r.wr_inc
        |=> st_r.addr == ADDR_W'($past(st_r.addr) + 1'b1))
        else $error("address did not step after a written byte");
    write_target_a: assert property (st_r.state == S_DATA_IN |-> st_r.wlatch)
        else $error("write data phase entered with latch clear");
    wr_only_write_a: assert property (st_r.wr_stb |-> st_r.op == OP_MEM_WRITE)
        else $error("memory write strobe outside a memory write");
    rd_only_read_a: assert property (st_r.rd_stb |-> st_r.op == OP_MEM_READ)
        else $error("memory read strobe outside a memory read");
    sleep_from_op_a: assert property (st_r.sleep_stb
        |-> st_r.op == OP_SLEEP && $past(st_r.state) == S_OPCODE)
        else $error("sleep strobe without sleep opcode");
    status_out_a: assert property (p.cs_act && !p.cs_fall && p.sck_fall
        && st_r.state == S_DATA_OUT && st_r.op == OP_SR_READ && st_r.bitcnt == BIT_MSB
        |=> st_r.so == $past(status_reg[7]))
        else $error("status byte not loaded into the output");
endmodule

`default_nettype wire

// *** hw/sfe_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sfe_pin_if;
    logic cs_act;
    logic cs_fall;
    logic cs_rise;
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic si_lvl;

    modport drv (
        output cs_act,
        output cs_fall,
        output cs_rise,
        output sck_lvl,
        output sck_rise,
        output sck_fall,
        output si_lvl
    );

    modport use_side (
        input cs_act,
        input cs_fall,
        input cs_rise,
        input sck_lvl,
        input sck_rise,
        input sck_fall,
        input si_lvl
    );
endinterface

`default_nettype wire

// *** hw/sfe_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfe_pin_sync
    import sfe_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    sfe_pin_if.drv pins
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } sfe_sync_t;

    sfe_sync_t sy_r;
    sfe_sync_t sy_nxt;

    // two stages per pin, third stage only for edge finding
    always_comb begin
        sy_nxt = sy_r;
        sy_nxt.s1 = {cs_n, sck, si};
        sy_nxt.s2 = sy_r.s1;
        sy_nxt.s3 = sy_r.s2;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sy_r.s1 <= SYNC_RST;
            sy_r.s2 <= SYNC_RST;
            sy_r.s3 <= SYNC_RST;
        end else begin
            sy_r <= sy_nxt;
        end
    end

    // levels and edges from settled stages only
    assign pins.cs_act = ~sy_r.s2[2];
    assign pins.cs_fall = ~sy_r.s2[2] & sy_r.s3[2];
    assign pins.cs_rise = sy_r.s2[2] & ~sy_r.s3[2];
    assign pins.sck_lvl = sy_r.s2[1];
    assign pins.sck_rise = sy_r.s2[1] & ~sy_r.s3[1];
    assign pins.sck_fall = ~sy_r.s2[1] & sy_r.s3[1];
    assign pins.si_lvl = sy_r.s2[0];
endmodule

`default_nettype wire

// *** hw/sfe_pkg.sv ***
package sfe_pkg;

    // opcodes, shifted msb first
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_SR_READ = 8'h05;
    localparam logic [7:0] OP_SR_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_SLEEP = 8'hB9;

    // bit and byte counting
    localparam logic [2:0] BIT_MSB = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h0;
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

    // status byte layout and fixed bits
    localparam int SR_LATCH_BIT = 1;
    localparam int SR_BP0_BIT = 2;
    localparam int SR_BP1_BIT = 3;
    localparam int SR_WPEN_BIT = 7;
    localparam logic [7:0] SR_FIXED = 8'h40;

    // value of the synchroniser stages at reset: select high, clock and data low
    localparam logic [2:0] SYNC_RST = 3'h4;

    // protocol states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_OPCODE = 7'h02,
        S_ADDR = 7'h04,
        S_DATA_IN = 7'h08,
        S_DATA_OUT = 7'h10,
        S_IGNORE = 7'h20,
        S_DONE = 7'h40
    } sfe_state_t;

endpackage

// *** hw/unused_placeholder_none.sv ***
`default_nettype wire
